// >>> rcw_cfg.svh
`ifndef RCW_CFG_SVH
`define RCW_CFG_SVH

// ----------------------------------------
// Control word n+2 bit positions
// ----------------------------------------
`define RCW_BIT_WR_SV1 0
`define RCW_BIT_WR_SV2 1
`define RCW_BIT_WR_PV 2
`define RCW_BIT_BCD 3
`define RCW_BIT_RD_SV1 4
`define RCW_BIT_RD_SV2 5
`define RCW_BIT_RD_PV 6
`define RCW_BIT_RUN 8
`define RCW_MODE_LSB 10
`define RCW_MODE_MSB 11

// ----------------------------------------
// Interface status word bits
// ----------------------------------------
`define RCW_STAT_REFRESH 15
`define RCW_STAT_POWER 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RCW_VAL_RST 32'h0000_0000
`define RCW_WORD_RST 16'h0000

`endif

// >>> rcw_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
// Port checks, quiet until the reset pipe has drained
module rcw_chk (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [15:0] out_word0_i,
  input wire logic [15:0] out_word1_i,
  input wire logic [15:0] out_word2_i,
  input wire logic unit_power_ok_i,
  input wire logic io_refresh_i,
  input wire logic phase_a_i,
  input wire logic phase_b_i,
  input wire logic [15:0] if_status0_o,
  input wire logic [15:0] if_status1_o,
  input wire logic [15:0] data_word_m_o,
  input wire logic [15:0] data_word_m1_o,
  input wire logic ext_out1_o,
  input wire logic ext_out2_o
);
  logic [1:0] age_q; // Edges since release, saturating
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) age_q <= 2'h0;
    else if (age_q != 2'h3) age_q <= age_q + 2'h1;
  end
  wire logic pw = unit_power_ok_i;
  wire logic [15:0] c = out_word2_i;
  wire logic [31:0] v = {out_word1_i, out_word0_i};
  wire logic [31:0] rd = {data_word_m1_o, data_word_m_o};
  wire logic ex = ext_out1_o | ext_out2_o;
  default clocking @(posedge core_clk_i); endclocking
  // Outputs are forced low for two edges after release
  default disable iff (!arst_n_i || age_q != 2'h3);
  sequence wr_rd(w, r);
    pw && c[11:0] == w ##1 pw && c[11:0] == r && $stable(v);
  endsequence
  property rb_p(w, r);
    wr_rd(w, r) |=> rd == $past(v);
  endproperty
  rd_sv1_a: assert property (rb_p(12'h001, 12'h070))
    else $error("sv1 readback wrong");
  rd_pv_a: assert property (rb_p(12'h104, 12'h140))
    else $error("pv readback wrong");
  // Plain write of twelve into set value 1, then a coded read of it
  sequence bcd_wr_rd;
    pw && c[11:0] == 12'h001 && v == 32'hc ##1 pw && c[11:0] == 12'h018;
  endsequence
  // Counting in one mode, a new mode with no write, then a plain count read
  sequence mode_swap;
    pw && c[8] && c[11:10] != 2'h0
    ##1 pw && c[8] && c[2:0] == 3'h0 && c[11:10] != $past(c[11:10])
    ##1 c[6:0] == 7'h40;
  endsequence
  bcd_rd_a: assert property (bcd_wr_rd |=> rd == 32'h12)
    else $error("bcd readback wrong");
  mode_clr_a: assert property (mode_swap |=> rd == 32'h0)
    else $error("count kept after mode change");
  rd_none_a: assert property (pw && (c[2:0] != 3'h0 || c[6:4] == 3'h0) |=> rd == 32'h0)
    else $error("readback not blocked");
  refresh_a: assert property (io_refresh_i && pw |=> if_status0_o[15] && if_status0_o[0])
    else $error("refresh flag low");
  stat_one_a: assert property (if_status1_o == 16'h0)
    else $error("status word 1 not zero");
  power_a: assert property (!pw [*2] |=> !ex && !if_status0_o[15])
    else $error("outputs on without power");
  run_stop_a: assert property (!c[8] [*2] |=> !ex)
    else $error("outputs on while stopped");
  no_mode_a: assert property ((c[11:10] == 2'h0) [*2] |=> !ex)
    else $error("outputs on without mode");
endmodule
bind rcw_core rcw_chk u_rcw_chk (.*);
`default_nettype wire

// >>> rcw_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcw_cfg.svh"

module rcw_core
  import rcw_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [15:0] out_word0_i,
  input wire logic [15:0] out_word1_i,
  input wire logic [15:0] out_word2_i,
  input wire logic unit_power_ok_i,
  input wire logic io_refresh_i,
  input wire logic phase_a_i,
  input wire logic phase_b_i,
  output logic [15:0] if_status0_o,
  output logic [15:0] if_status1_o,
  output logic [15:0] data_word_m_o,
  output logic [15:0] data_word_m1_o,
  output logic ext_out1_o,
  output logic ext_out2_o
);
  // ----------------------------------------
  // Code conversion helpers
  // ----------------------------------------
  // Eight BCD digits to binary; digit values above 9 are taken as read
  function automatic logic [31:0] bcd_to_bin(input logic [31:0] b);
    logic [31:0] acc;
    acc = 32'h0000_0000;
    for (int i = 7; i >= 0; i--) begin
      acc = 32'((acc << 3) + (acc << 1)) + {28'h000_0000, b[i*4 +: 4]};
    end
    return acc;
  endfunction

  // Binary to eight BCD digits; values above 99999999 keep only their low eight digits
  function automatic logic [31:0] bin_to_bcd(input logic [31:0] v);
    logic [31:0] d;
    d = 32'h0000_0000;
    for (int i = 31; i >= 0; i--) begin
      for (int k = 0; k < 8; k++) begin
        if (d[k*4 +: 4] > 4'h4) begin
          d[k*4 +: 4] = d[k*4 +: 4] + 4'h3;
        end
      end
      d = {d[30:0], v[i]};
    end
    return d;
  endfunction

  // Word pair to value, honouring the data code
  function automatic logic [31:0] word_in(input logic [31:0] w, input logic bcd);
    return bcd ? bcd_to_bin(w) : w;
  endfunction

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_meta_q; // First stage, read only by second
  logic rst_n_q; // Released reset used everywhere

  // Two-stage release of the asynchronous reset
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ----------------------------------------
  // Control word decode
  // ----------------------------------------
  wire [31:0] wr_pair = {out_word1_i, out_word0_i};
  wire bcd_sel = out_word2_i[`RCW_BIT_BCD];
  wire rcw_mode_t mode_req = rcw_mode_t'(out_word2_i[`RCW_MODE_MSB:`RCW_MODE_LSB]);
  wire run_req = out_word2_i[`RCW_BIT_RUN];
  // Lower bit number wins; any request bit above it is ignored
  wire req_sv1 = out_word2_i[`RCW_BIT_WR_SV1];
  wire req_sv2 = out_word2_i[`RCW_BIT_WR_SV2] & ~req_sv1;
  wire req_pv = out_word2_i[`RCW_BIT_WR_PV] & ~(|out_word2_i[1:0]);
  wire any_wr = |out_word2_i[2:0];
  wire rd_sv1 = out_word2_i[`RCW_BIT_RD_SV1] & ~any_wr;
  wire rd_sv2 = out_word2_i[`RCW_BIT_RD_SV2] & ~any_wr & ~rd_sv1;
  wire rd_pv = out_word2_i[`RCW_BIT_RD_PV] & ~any_wr & ~out_word2_i[`RCW_BIT_RD_SV1]
    & ~out_word2_i[`RCW_BIT_RD_SV2];
  wire rcw_rb_t rb_sel = rd_sv1 ? RCW_RB_SV1 : rd_sv2 ? RCW_RB_SV2 : rd_pv ? RCW_RB_PV : RCW_RB_NONE;
  wire [31:0] wr_val = word_in(wr_pair, bcd_sel);

  // ----------------------------------------
  // Settings and count state
  // ----------------------------------------
  logic [31:0] sv1_q; // Set value 1
  logic [31:0] sv2_q; // Set value 2
  logic [31:0] pv_q; // Present count
  rcw_mode_t mode_q; // Accepted count mode
  logic [31:0] rb_q; // Readback word pair
  logic out1_q; // External output 1
  logic out2_q; // External output 2
  logic up_step; // Step from phase decoder
  logic down_step;

  // Counting only with supply, run bit set and a mode chosen
  wire counting = unit_power_ok_i & run_req & (mode_q != RCW_MODE_NONE);
  wire mode_chg = (mode_req != mode_q);

  rcw_quad u_rcw_quad (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_q),
    .phase_a_i(phase_a_i),
    .phase_b_i(phase_b_i),
    .mode_i(mode_q),
    .up_o(up_step),
    .down_o(down_step)
  );

  // Next count: reload beats clear, clear beats stepping
  logic [31:0] pv_d;
  always_comb begin
    pv_d = pv_q;
    if (req_pv) begin
      pv_d = wr_val;
    end else if (mode_chg && counting) begin
      pv_d = `RCW_VAL_RST;
    end else if (!run_req) begin
      pv_d = `RCW_VAL_RST;
    end else if (counting && up_step) begin
      pv_d = pv_q + 32'h0000_0001;
    end else if (counting && down_step) begin
      pv_d = pv_q - 32'h0000_0001;
    end
  end

  // Settings; supply loss acts like a restart and clears them all
  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sv1_q <= `RCW_VAL_RST;
      sv2_q <= `RCW_VAL_RST;
      pv_q <= `RCW_VAL_RST;
      mode_q <= RCW_MODE_NONE;
    end else if (!unit_power_ok_i) begin
      sv1_q <= `RCW_VAL_RST;
      sv2_q <= `RCW_VAL_RST;
      pv_q <= `RCW_VAL_RST;
      mode_q <= RCW_MODE_NONE;
    end else begin
      if (req_sv1) begin
        sv1_q <= wr_val;
      end
      if (req_sv2) begin
        sv2_q <= wr_val;
      end
      pv_q <= pv_d;
      mode_q <= mode_req;
    end
  end

  // ----------------------------------------
  // Readback and external outputs
  // ----------------------------------------
  logic [31:0] rb_raw;
  always_comb begin
    case (rb_sel)
      RCW_RB_SV1: rb_raw = sv1_q;
      RCW_RB_SV2: rb_raw = sv2_q;
      RCW_RB_PV: rb_raw = pv_q;
      default: rb_raw = `RCW_VAL_RST;
    endcase
  end

  // Refreshed every cycle so the selected value tracks the count
  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rb_q <= `RCW_VAL_RST;
      out1_q <= 1'b0;
      out2_q <= 1'b0;
    end else begin
      rb_q <= bcd_sel ? bin_to_bcd(rb_raw) : rb_raw;
      out1_q <= counting & (pv_q >= sv1_q);
      out2_q <= counting & (pv_q >= sv2_q);
    end
  end

  // ----------------------------------------
  // Status words
  // ----------------------------------------
  logic [15:0] st0_q;
  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st0_q <= `RCW_WORD_RST;
    end else begin
      st0_q <= `RCW_WORD_RST;
      st0_q[`RCW_STAT_REFRESH] <= io_refresh_i & unit_power_ok_i;
      st0_q[`RCW_STAT_POWER] <= unit_power_ok_i;
    end
  end

  // Interface status always leads; unit data follows it
  assign if_status0_o = st0_q;
  assign if_status1_o = `RCW_WORD_RST;
  assign data_word_m_o = rb_q[15:0];
  assign data_word_m1_o = rb_q[31:16];
  assign ext_out1_o = out1_q;
  assign ext_out2_o = out2_q;
endmodule
`default_nettype wire

// >>> rcw_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// Master side: posts whole words, counts refresh restarts
module rcw_master_model (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [15:0] cmd_i,
  input wire logic [31:0] val_i,
  input wire logic stat15_i,
  output logic [15:0] word0_o,
  output logic [15:0] word1_o,
  output logic [15:0] word2_o,
  output logic [3:0] n_init_o
);
  logic stat15_q; // Last refresh flag seen
  // Word n+2 moves in one step so request bits never race
  always_ff @(posedge core_clk_i) begin
    word2_o <= cmd_i;
    {word1_o, word0_o} <= val_i;
  end
  // Rising refresh flag asks for a fresh setup
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stat15_q <= 1'b0;
      n_init_o <= 4'h0;
    end else begin
      stat15_q <= stat15_i;
      if (stat15_i && !stat15_q) n_init_o <= n_init_o + 4'h1;
    end
  end
endmodule
`default_nettype wire

// >>> rcw_pkg.sv
`default_nettype none
package rcw_pkg;
  // Count mode field encodings
  typedef enum logic [1:0] {
    RCW_MODE_NONE = 2'b00,
    RCW_MODE_UPDN = 2'b01,
    RCW_MODE_PDIR = 2'b10,
    RCW_MODE_QX1 = 2'b11
  } rcw_mode_t;

  // Readback source after priority resolution
  typedef enum logic [1:0] {
    RCW_RB_NONE,
    RCW_RB_SV1,
    RCW_RB_SV2,
    RCW_RB_PV
  } rcw_rb_t;
endpackage
`default_nettype wire

// >>> rcw_quad.sv
`timescale 1ns/1ps
`default_nettype none
// Turns phase inputs into one-cycle up/down steps for the chosen mode
module rcw_quad
  import rcw_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic phase_a_i,
  input wire logic phase_b_i,
  input wire rcw_mode_t mode_i,
  output logic up_o,
  output logic down_o
);
  // ----------------------------------------
  // Edge detection
  // ----------------------------------------
  logic a_q; // Previous phase A
  logic b_q; // Previous phase B
  wire a_rise = phase_a_i & ~a_q;
  wire a_fall = ~phase_a_i & a_q;
  wire b_rise = phase_b_i & ~b_q;

  // Previous levels; inputs already synchronous
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
    end else begin
      a_q <= phase_a_i;
      b_q <= phase_b_i;
    end
  end

  // Step decode per mode; single-multiplied quadrature uses A edges with B low
  always_comb begin
    up_o = 1'b0;
    down_o = 1'b0;
    case (mode_i)
      RCW_MODE_QX1: begin
        up_o = a_rise & ~phase_b_i;
        down_o = a_fall & ~phase_b_i;
      end
      RCW_MODE_UPDN: begin
        up_o = a_rise;
        down_o = b_rise;
      end
      RCW_MODE_PDIR: begin
        up_o = a_rise & ~phase_b_i;
        down_o = a_rise & phase_b_i;
      end
      default: begin
        // No mode set: no counting
        up_o = 1'b0;
        down_o = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0; // Active-low reset
  logic [15:0] cmd = 16'h0000; // Requested word n+2
  logic [31:0] val = 32'h0;
  logic pwr = 1'b1;
  logic io_ref = 1'b0;
  logic pa = 1'b0;
  logic pb = 1'b0;
  logic [15:0] w0, w1, w2, st0, st1, dm, dm1;
  logic e1, e2;
  logic [3:0] n_init;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  initial forever #4 clk = ~clk;
  rcw_master_model u_rcw_master_model (.core_clk_i(clk), .arst_n_i(rst_n), .cmd_i(cmd), .val_i(val),
    .stat15_i(st0[15]), .word0_o(w0), .word1_o(w1), .word2_o(w2), .n_init_o(n_init));
  rcw_core u_rcw_core (.core_clk_i(clk), .arst_n_i(rst_n), .out_word0_i(w0), .out_word1_i(w1),
    .out_word2_i(w2), .unit_power_ok_i(pwr), .io_refresh_i(io_ref), .phase_a_i(pa), .phase_b_i(pb),
    .if_status0_o(st0), .if_status1_o(st1), .data_word_m_o(dm), .data_word_m1_o(dm1),
    .ext_out1_o(e1), .ext_out2_o(e2));
  task automatic close_out;
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Post one word set, then let it travel through model and core
  task automatic put(input logic [15:0] c, input logic [31:0] v);
    @(posedge clk);
    cmd <= c;
    val <= v;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic wr_rd(input logic [15:0] w, input logic [15:0] r, input logic [31:0] v, input logic [31:0] e);
    put(w, v);
    put(r, v);
    chk({dm1, dm}, e);
  endtask
  // Four phase states, oldest in the top bits
  task automatic step(input logic [7:0] s);
    for (int i = 3; i >= 0; i--) begin
      @(posedge clk);
      {pa, pb} <= s[2*i+:2];
    end
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic do_rst;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  // Hang guard, far above the expected few hundred cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      close_out;
    end
  end
  initial begin
    do_rst;
    io_ref <= 1'b1;
    put(16'h0000, 32'h0);
    chk({st1, st0}, 32'h8001);
    chk({28'h0, n_init}, 32'h1);
    wr_rd(16'h0104, 16'h0140, 32'h7, 32'h7);
    wr_rd(16'h0001, 16'h0070, 32'h0001_2345, 32'h0001_2345);
    wr_rd(16'h0001, 16'h0018, 32'hc, 32'h12);
    wr_rd(16'h0009, 16'h0010, 32'h12, 32'hc);
    wr_rd(16'h0011, 16'h0011, 32'h5, 32'h0);
    wr_rd(16'h0002, 16'h0060, 32'h4, 32'h4);
    wr_rd(16'h0001, 16'h0010, 32'h2, 32'h2);
    put(16'h0d40, 32'h0);
    repeat (4) step(8'hb4);
    chk({dm1, dm}, 32'h4);
    chk({30'h0, e2, e1}, 32'h3);
    step(8'h78);
    chk({30'h0, e2, e1}, 32'h1);
    put(16'h0940, 32'h0);
    chk({dm1, dm}, 32'h0);
    step(8'hb4);
    chk({dm1, dm}, 32'h1);
    put(16'h0c40, 32'h0);
    chk({dm1, dm}, 32'h0);
    put(16'h0140, 32'h0);
    step(8'hb4);
    chk({dm1, dm}, 32'h0);
    put(16'h0d40, 32'h0);
    repeat (2) step(8'hb4);
    chk({30'h0, e2, e1}, 32'h1);
    // Up/down mode: two B rises step the cleared count below zero
    put(16'h0540, 32'h0);
    step(8'h44);
    chk({dm1, dm}, 32'hffff_fffe);
    chk({30'h0, e2, e1}, 32'h3);
    @(posedge clk);
    pwr <= 1'b0;
    put(16'h0d40, 32'h0);
    chk({st0, 14'h0, e2, e1}, 32'h0);
    @(posedge clk);
    pwr <= 1'b1;
    put(16'h0010, 32'h0);
    chk({dm1, dm}, 32'h0);
    chk({28'h0, n_init}, 32'h2);
    wr_rd(16'h0001, 16'h0010, 32'h2, 32'h2);
    do_rst;
    put(16'h0010, 32'h0);
    chk({dm1, dm}, 32'h0);
    close_out;
  end
endmodule
`default_nettype wire
